// File: hw/arcu_pkg.sv
// Package of constants and carrier types for the result computation unit
package arcu_pkg;
    localparam int RES_W = 12;
    localparam int ACC_W = 18;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_SAT = 8'hff;
    localparam logic [ACC_W-1:0] ACC_RST = 18'h00000;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam int FIFO_DEPTH = 16;
    // Conversion wait inside a burst, in ns; CONV_CYC rounds it up to cycles
    localparam int CONV_NS = 40;
    localparam int CLK_NS = 4;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ARCU_BASIC = 3'h0,
        ARCU_ACCUM = 3'h1,
        ARCU_AVG = 3'h2,
        ARCU_BURST = 3'h3,
        ARCU_LPF = 3'h4
    } arcu_mode_e;

    typedef struct packed {
        logic [RES_W-1:0] latest_result;
        logic [RES_W-1:0] previous_result;
    } arcu_sample_s;

    typedef struct packed {
        logic [ACC_W-1:0] accumulator_value;
        logic [ACC_W-1:0] filter_output;
        logic [CNT_W-1:0] sample_count;
        logic accumulator_overflow;
        logic test_due;
    } arcu_result_s;
endpackage : arcu_pkg

// File: hw/arcu_fifo.sv
// Parameterised valid/ready FIFO in front of the computation unit
`timescale 1ns/100ps
module arcu_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } arcu_fifo_s;
    arcu_fifo_s st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign empty = st.wr == st.rd;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;
    assign out_data = mem[st.rd[AW-1:0]];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wr[AW-1:0]] <= in_data;
        end
    end
endmodule : arcu_fifo

// File: hw/arcu_top.sv
// Post-conversion computation unit: accumulate, average, burst and low-pass
//
// Function
// - Compute mode 0..4 selects basic, accumulate, average, burst average, low-pass.
// - Basic mode converts singles or pairs; done flag after every conversion.
// - A cycle is one conversion, or two with double sampling on.
// - Accumulate mode adds result, increments counter, sets done flag each time.
// - Sample counter increments per cycle in modes 1..4 but holds at 0xff.
// - Average mode tests threshold only once counter reaches repeat target.
// - Average mode: trigger after a test clears accumulator and counter first.
// - Average mode needs a fresh set of samples for every test.
// - Burst: clear on trigger, retrigger while counter below target, test at end.
// - Burst ends with counter equal to repeat target at the threshold flag.
// - Low-pass: accumulator becomes sample plus accumulator minus shifted accumulator.
// - Low-pass: after target reached, every trigger filters and tests again.
// - Filter output takes shifted accumulator after each accumulation.
// - Clear request empties accumulator, overflow and counter, then self-clears.
// - Accumulator is 18 bits; overflow flag set past 262143.
`timescale 1ns/100ps
module arcu_top #(
    parameter int DEPTH = arcu_pkg::FIFO_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [2:0] COMPUTE_MODE_SELECT,
    input wire logic DOUBLE_SAMPLE_ENABLE,
    input wire logic [arcu_pkg::CNT_W-1:0] REPEAT_TARGET,
    input wire logic [2:0] SHIFT_AMOUNT,
    input wire logic ACCUMULATOR_CLEAR_SET,
    input wire logic TRIGGER,
    input wire logic RESULT_VALID,
    output logic RESULT_READY,
    input wire logic [arcu_pkg::RES_W-1:0] LATEST_RESULT,
    output logic CONVERT_START,
    output logic CONVERSION_DONE_FLAG,
    output logic TEST_STROBE,
    output logic THRESHOLD_HIT_FLAG,
    input wire logic THRESHOLD_MET,
    output logic ACCUMULATOR_CLEAR,
    output logic [arcu_pkg::ACC_W-1:0] ACCUMULATOR_VALUE,
    output logic [arcu_pkg::ACC_W-1:0] FILTER_OUTPUT,
    output logic [arcu_pkg::CNT_W-1:0] SAMPLE_COUNTER,
    output logic ACCUMULATOR_OVERFLOW
);
    import arcu_pkg::*;

    // ==========================================================
    // Types and state
    typedef enum logic [1:0] {
        ARCU_IDLE,
        ARCU_BURSTING,
        ARCU_WAIT
    } arcu_burst_e;

    typedef struct packed {
        arcu_burst_e burst;
        logic [7:0] wait_cnt;
        logic [RES_W-1:0] previous_result;
        logic phase;
        logic clear_pending;
        logic tested;
        logic start;
        logic done;
        logic test;
        logic hit;
        arcu_result_s res;
    } arcu_state_s;

    arcu_state_s st, next_st;
    arcu_mode_e mode;
    logic [RES_W-1:0] fifo_data;
    logic fifo_valid;
    logic take;
    logic [ACC_W:0] sum;
    logic [ACC_W:0] base;
    logic [ACC_W:0] sample_term;
    logic cycle_end;
    logic clear_acc;
    logic trig;
    logic in_trig_sync1;
    logic in_trig_sync2;
    logic in_trig_prev;

    function automatic logic [ACC_W-1:0] shr(input logic [ACC_W-1:0] v, input logic [2:0] s);
        shr = v >> s;
    endfunction : shr

    // ==========================================================
    // Result buffer
    arcu_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst(RESET),
        .in_valid(RESULT_VALID),
        .in_ready(RESULT_READY),
        .in_data(LATEST_RESULT),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );

    // ==========================================================
    // Trigger pin synchroniser and edge detect
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            in_trig_sync1 <= 1'b0;
            in_trig_sync2 <= 1'b0;
            in_trig_prev <= 1'b0;
        end else begin
            in_trig_sync1 <= TRIGGER;
            in_trig_sync2 <= in_trig_sync1;
            in_trig_prev <= in_trig_sync2;
        end
    end
    assign trig = in_trig_sync2 && !in_trig_prev;

    // ==========================================================
    // Computation
    assign mode = arcu_mode_e'(COMPUTE_MODE_SELECT);
    assign take = fifo_valid;
    assign cycle_end = take && (!DOUBLE_SAMPLE_ENABLE || st.phase);

    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        next_st.done = 1'b0;
        next_st.test = 1'b0;
        sum = '0;
        base = '0;
        sample_term = '0;
        clear_acc = 1'b0;
        // Trigger-time clears
        if (trig) begin
            if (mode == ARCU_AVG && st.tested) begin
                clear_acc = 1'b1;
            end
            if (mode == ARCU_BURST) begin
                clear_acc = 1'b1;
                next_st.burst = ARCU_BURSTING;
            end
            next_st.start = 1'b1;
            next_st.tested = 1'b0;
        end
        if (clear_acc) begin
            next_st.res.accumulator_value = ACC_RST;
            next_st.res.sample_count = CNT_RST;
            next_st.res.accumulator_overflow = 1'b0;
        end
        if (take) begin
            next_st.previous_result = fifo_data;
            next_st.done = 1'b1;
            next_st.phase = DOUBLE_SAMPLE_ENABLE ? !st.phase : 1'b0;
        end
        if (cycle_end) begin
            if (DOUBLE_SAMPLE_ENABLE) begin
                sample_term = (ACC_W+1)'(fifo_data) - (ACC_W+1)'(st.previous_result);
            end else begin
                sample_term = (ACC_W+1)'(fifo_data);
            end
            base = {1'b0, next_st.res.accumulator_value};
            if (mode == ARCU_LPF) begin
                base = base - {1'b0, shr(next_st.res.accumulator_value, SHIFT_AMOUNT)};
            end
            sum = base + sample_term;
            // Unused codes behave as basic: no accumulation
            if (mode inside {ARCU_ACCUM, ARCU_AVG, ARCU_BURST, ARCU_LPF}) begin
                next_st.res.accumulator_value = sum[ACC_W-1:0];
                next_st.res.filter_output = shr(sum[ACC_W-1:0], SHIFT_AMOUNT);
                if (sum[ACC_W] && !sample_term[ACC_W]) begin
                    next_st.res.accumulator_overflow = 1'b1;
                end
                if (next_st.res.sample_count != CNT_SAT) begin
                    next_st.res.sample_count = next_st.res.sample_count + 1'b1;
                end
            end
            unique case (mode)
                ARCU_BASIC, ARCU_ACCUM: next_st.test = 1'b1;
                ARCU_AVG, ARCU_LPF: begin
                    next_st.test = next_st.res.sample_count >= REPEAT_TARGET;
                end
                ARCU_BURST: next_st.test = next_st.res.sample_count >= REPEAT_TARGET;
                default: next_st.test = 1'b1;
            endcase
            if (mode == ARCU_AVG && next_st.test) begin
                next_st.tested = 1'b1;
            end
            if (mode == ARCU_BURST && st.burst != ARCU_IDLE) begin
                if (next_st.res.sample_count < REPEAT_TARGET) begin
                    next_st.burst = ARCU_WAIT;
                    next_st.wait_cnt = 8'(CONV_CYC);
                end else begin
                    next_st.burst = ARCU_IDLE;
                end
            end
        end
        // Second conversion of a pair and burst retriggers
        if (take && DOUBLE_SAMPLE_ENABLE && !st.phase) begin
            next_st.start = 1'b1;
        end
        if (st.burst == ARCU_WAIT && !cycle_end) begin
            if (st.wait_cnt == 8'h00) begin
                next_st.start = 1'b1;
                next_st.burst = ARCU_BURSTING;
            end else begin
                next_st.wait_cnt = st.wait_cnt - 1'b1;
            end
        end
        next_st.res.test_due = next_st.test;
        next_st.hit = next_st.test && (THRESHOLD_MET || next_st.res.accumulator_overflow);
        // Software clear request, applied one cycle later
        if (st.clear_pending) begin
            next_st.res.accumulator_value = ACC_RST;
            next_st.res.sample_count = CNT_RST;
            next_st.res.accumulator_overflow = 1'b0;
            next_st.clear_pending = 1'b0;
        end
        if (ACCUMULATOR_CLEAR_SET) begin
            next_st.clear_pending = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            st <= '{burst: ARCU_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign CONVERT_START = st.start;
    assign CONVERSION_DONE_FLAG = st.done;
    assign TEST_STROBE = st.test;
    assign THRESHOLD_HIT_FLAG = st.hit;
    assign ACCUMULATOR_CLEAR = st.clear_pending;
    assign ACCUMULATOR_VALUE = st.res.accumulator_value;
    assign FILTER_OUTPUT = st.res.filter_output;
    assign SAMPLE_COUNTER = st.res.sample_count;
    assign ACCUMULATOR_OVERFLOW = st.res.accumulator_overflow;
endmodule : arcu_top

// File: verif/arcu_top_monitor.sv
// Port checker for the result computation unit
`timescale 1ns/100ps
module arcu_top_monitor (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [2:0] COMPUTE_MODE_SELECT,
    input wire logic DOUBLE_SAMPLE_ENABLE,
    input wire logic [arcu_pkg::CNT_W-1:0] REPEAT_TARGET,
    input wire logic [2:0] SHIFT_AMOUNT,
    input wire logic ACCUMULATOR_CLEAR_SET,
    input wire logic RESULT_VALID,
    input wire logic RESULT_READY,
    input wire logic CONVERT_START,
    input wire logic CONVERSION_DONE_FLAG,
    input wire logic TEST_STROBE,
    input wire logic ACCUMULATOR_CLEAR,
    input wire logic [arcu_pkg::ACC_W-1:0] ACCUMULATOR_VALUE,
    input wire logic [arcu_pkg::ACC_W-1:0] FILTER_OUTPUT,
    input wire logic [arcu_pkg::CNT_W-1:0] SAMPLE_COUNTER,
    input wire logic ACCUMULATOR_OVERFLOW
);
    import arcu_pkg::*;
    // ====
    // Port relations
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    property p_take; RESULT_VALID && RESULT_READY |-> ##2 CONVERSION_DONE_FLAG; endproperty
    a_take: assert property (p_take) else $error("no done");
    property p_clr; ACCUMULATOR_CLEAR_SET |=> ACCUMULATOR_CLEAR ##1 (!ACCUMULATOR_OVERFLOW
        && ACCUMULATOR_VALUE == ACC_RST && SAMPLE_COUNTER == CNT_RST); endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_self; ACCUMULATOR_CLEAR && !ACCUMULATOR_CLEAR_SET
        |=> !ACCUMULATOR_CLEAR; endproperty
    a_self: assert property (p_self) else $error("clear stuck");
    property p_step; $changed(SAMPLE_COUNTER) && SAMPLE_COUNTER != CNT_RST
        |-> SAMPLE_COUNTER == $past(SAMPLE_COUNTER) + 8'h01; endproperty
    a_step: assert property (p_step) else $error("count step");
    property p_sat; SAMPLE_COUNTER == CNT_SAT && COMPUTE_MODE_SELECT == ARCU_ACCUM
        && !ACCUMULATOR_CLEAR && !ACCUMULATOR_CLEAR_SET |=> SAMPLE_COUNTER == CNT_SAT; endproperty
    a_sat: assert property (p_sat) else $error("count wrap");
    property p_filt; CONVERSION_DONE_FLAG && !DOUBLE_SAMPLE_ENABLE && $stable(SHIFT_AMOUNT)
        && COMPUTE_MODE_SELECT inside {[3'h1:3'h4]}
        |-> FILTER_OUTPUT == ACCUMULATOR_VALUE >> SHIFT_AMOUNT; endproperty
    a_filt: assert property (p_filt) else $error("filter");
    property p_avg; TEST_STROBE && COMPUTE_MODE_SELECT == ARCU_AVG
        |-> SAMPLE_COUNTER >= REPEAT_TARGET && CONVERSION_DONE_FLAG; endproperty
    a_avg: assert property (p_avg) else $error("early test");
    property p_burst; TEST_STROBE && COMPUTE_MODE_SELECT == ARCU_BURST
        |-> SAMPLE_COUNTER == REPEAT_TARGET; endproperty
    a_burst: assert property (p_burst) else $error("burst end");
    property p_rtrg; CONVERSION_DONE_FLAG && COMPUTE_MODE_SELECT == ARCU_BURST
        && !DOUBLE_SAMPLE_ENABLE && SAMPLE_COUNTER < REPEAT_TARGET |-> ##[1:14] CONVERT_START;
    endproperty
    a_rtrg: assert property (p_rtrg) else $error("no retrigger");
endmodule : arcu_top_monitor

bind arcu_top arcu_top_monitor mon (.*);

// File: verif/arcu_core_model.sv
// Behavioural conversion core answering convert requests
`timescale 1ns/100ps
module arcu_core_model (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic CONVERT_START,
    input wire logic RESULT_READY,
    input wire logic [3:0] CORE_DELAY,
    input wire logic [11:0] CORE_BASE,
    input wire logic [11:0] CORE_STEP,
    output logic RESULT_VALID,
    output logic [11:0] LATEST_RESULT
);
    int pend;
    int gap;
    int n;
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            RESULT_VALID <= 1'b0;
            LATEST_RESULT <= 12'h000;
            pend = 0;
            gap = 0;
            n = 0;
        end else begin
            if (CONVERT_START)
                pend = pend + 1;
            if (RESULT_VALID && RESULT_READY) begin
                // Released data shows the inverse of the last value
                RESULT_VALID <= 1'b0;
                LATEST_RESULT <= ~LATEST_RESULT;
                n = n + 1;
                pend = pend - 1;
                gap = 0;
            end else if (!RESULT_VALID && pend > 0) begin
                if (gap >= CORE_DELAY) begin
                    RESULT_VALID <= 1'b1;
                    LATEST_RESULT <= CORE_BASE + 12'(n) * CORE_STEP;
                end
                gap = gap + 1;
            end
        end
    end
endmodule : arcu_core_model

// File: verif/arcu_top_tb.sv
// Self-checking bench for the result computation unit
`timescale 1ns/100ps
module arcu_top_tb;
    import arcu_pkg::*;
    logic REF_CLK, RESET, DOUBLE_SAMPLE_ENABLE, ACCUMULATOR_CLEAR_SET, TRIGGER, RESULT_VALID;
    logic RESULT_READY, CONVERT_START, CONVERSION_DONE_FLAG, TEST_STROBE, THRESHOLD_HIT_FLAG;
    logic THRESHOLD_MET, ACCUMULATOR_CLEAR, ACCUMULATOR_OVERFLOW, ovf;
    logic [2:0] COMPUTE_MODE_SELECT, SHIFT_AMOUNT;
    logic [3:0] CORE_DELAY;
    logic [RES_W-1:0] LATEST_RESULT, CORE_BASE, CORE_STEP;
    logic [CNT_W-1:0] REPEAT_TARGET, SAMPLE_COUNTER;
    logic [ACC_W-1:0] ACCUMULATOR_VALUE, FILTER_OUTPUT;
    logic [ACC_W:0] acc;
    int mismatches, cmp_count, n, cnt, tests, hits, dones;
    arcu_top dut (.*);
    arcu_core_model core (.*);
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        tests += int'(TEST_STROBE === 1'b1);
        hits += int'(THRESHOLD_HIT_FLAG === 1'b1);
        dones += int'(CONVERSION_DONE_FLAG === 1'b1);
    end
    // ====
    // Access tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic cfg(input logic [2:0] m, input logic d, input int t, input int s, input int w);
        COMPUTE_MODE_SELECT <= m;
        DOUBLE_SAMPLE_ENABLE <= d;
        REPEAT_TARGET <= CNT_W'(t);
        SHIFT_AMOUNT <= 3'(s);
        CORE_DELAY <= 4'(w);
        @(posedge REF_CLK);
    endtask : cfg
    task automatic clear();
        ACCUMULATOR_CLEAR_SET <= 1'b1;
        @(posedge REF_CLK);
        ACCUMULATOR_CLEAR_SET <= 1'b0;
        repeat (2) @(negedge REF_CLK);
        check("clear", {ACCUMULATOR_CLEAR, ACCUMULATOR_OVERFLOW,
            ACCUMULATOR_VALUE, SAMPLE_COUNTER}, 0);
        acc = 0;
        cnt = 0;
        ovf = 1'b0;
        @(posedge REF_CLK);
    endtask : clear
    task automatic go();
        int m, k, reps, t0, h0, d0, et;
        logic [RES_W-1:0] s;
        m = COMPUTE_MODE_SELECT;
        et = 0;
        if ((m == 2 && cnt >= REPEAT_TARGET) || m == 3) begin
            acc = 0;
            cnt = 0;
        end
        reps = (m == 3) ? int'(REPEAT_TARGET) : 1;
        for (int r = 0; r < reps; r++) begin
            s = CORE_BASE + 12'(n) * CORE_STEP;
            if (DOUBLE_SAMPLE_ENABLE)
                s = CORE_BASE + 12'(n + 1) * CORE_STEP - s;
            n += DOUBLE_SAMPLE_ENABLE ? 2 : 1;
            if (m == 4)
                acc = s + acc - (acc >> SHIFT_AMOUNT);
            else if (m != 0)
                acc = acc + s;
            if (m != 0 && cnt != 255)
                cnt++;
            ovf = ovf | acc[ACC_W];
            acc[ACC_W] = 1'b0;
            if (m <= 1 || cnt >= REPEAT_TARGET)
                et++;
        end
        k = reps * (DOUBLE_SAMPLE_ENABLE ? 2 : 1);
        t0 = tests;
        h0 = hits;
        d0 = dones;
        TRIGGER <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        TRIGGER <= 1'b1;
        @(posedge REF_CLK);
        TRIGGER <= 1'b0;
        // Wait for every result of this trigger, bounded
        for (int i = 0; i < 300 && dones - d0 < k; i++)
            @(negedge REF_CLK);
        repeat (3) @(negedge REF_CLK);
        check("dones", dones - d0, k);
        check("acc", ACCUMULATOR_VALUE, acc[ACC_W-1:0]);
        check("count", SAMPLE_COUNTER, cnt);
        check("filter", FILTER_OUTPUT, acc[ACC_W-1:0] >> SHIFT_AMOUNT);
        check("ovf", ACCUMULATOR_OVERFLOW, ovf);
        check("tests", tests - t0, et);
        check("hits", hits - h0, (THRESHOLD_MET || ovf) ? et : 0);
        @(posedge REF_CLK);
    endtask : go
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // ====
    // Test sequence
    initial begin
        {COMPUTE_MODE_SELECT, SHIFT_AMOUNT, CORE_DELAY, REPEAT_TARGET} = '0;
        {DOUBLE_SAMPLE_ENABLE, ACCUMULATOR_CLEAR_SET, TRIGGER, THRESHOLD_MET, ovf} = '0;
        CORE_BASE = 12'h010;
        CORE_STEP = 12'h003;
        acc = '0;
        RESET = 1'b1;
        repeat (12) @(posedge REF_CLK);
        RESET <= 1'b0;
        cfg(ARCU_ACCUM, 1'b1, 0, 0, 9);
        repeat (2) go();
        clear();
        cfg(ARCU_ACCUM, 1'b0, 0, 2, 0);
        repeat (3) go();
        cfg(ARCU_BASIC, 1'b0, 0, 2, 3);
        go();
        clear();
        cfg(ARCU_AVG, 1'b0, 2, 1, 1);
        repeat (4) go();
        clear();
        cfg(ARCU_LPF, 1'b0, 3, 1, 0);
        repeat (4) go();
        clear();
        THRESHOLD_MET <= 1'b1;
        cfg(ARCU_BURST, 1'b0, 3, 1, 2);
        repeat (2) go();
        THRESHOLD_MET <= 1'b0;
        clear();
        CORE_BASE <= 12'hfff;
        CORE_STEP <= 12'h000;
        cfg(ARCU_ACCUM, 1'b0, 0, 0, 0);
        repeat (257) go();
        print_verdict();
    end
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
endmodule : arcu_top_tb
